/* design/phy_status_defs.svh */
/*
  Offsets, field positions and reset values of the status latch registers.
  Assumes a 5-bit management register address as seen by the frame decoder.
*/
`ifndef PHY_STATUS_DEFS_SVH
`define PHY_STATUS_DEFS_SVH

// management register offsets
`define OFS_BASIC_LINK_STATUS    5'h01
`define OFS_NEGOTIATION_EXP      5'h06
`define OFS_LINK_DROP_CAUSE      5'h0f
`define OFS_PHY_CONDITION        5'h10
`define OFS_IRQ_SOURCE_STATUS    5'h12
`define OFS_BOGUS_CARRIER_COUNT  5'h14
`define OFS_RX_FAULT_COUNT       5'h15
`define OFS_TEN_MEG_STATUS_CTRL  5'h1a

// reset values
`define RST_PHY_CONDITION        16'h0000
`define RST_LINK_DROP_CAUSE      16'h0000

// link-drop cause field, one-hot codes within the field
`define DROP_FIELD_LSB           4
`define DROP_FIELD_MSB           8
`define DROP_CODE_ENERGY         5'h01
`define DROP_CODE_SNR            5'h02
`define DROP_CODE_MLT3           5'h04
`define DROP_CODE_RXERR          5'h08
`define DROP_CODE_DESCRAMBLER    5'h10

// condition register bit positions
`define PCS_CROSSOVER            14
`define PCS_RX_FAULT             13
`define PCS_POLARITY             12
`define PCS_BOGUS_CARRIER        11
`define PCS_SIGNAL_DETECT        10
`define PCS_DESCR_LOCK           9
`define PCS_PAGE_RECEIVED        8
`define PCS_IRQ_PENDING          7
`define PCS_REMOTE_FAULT         6
`define PCS_JABBER               5
`define PCS_AUTONEG_DONE         4
`define PCS_LOOPBACK             3
`define PCS_FULL_DUPLEX          2
`define PCS_SPEED_10             1
`define PCS_LINK_UP              0

// sticky bank slots: 0..4 are the drop causes
`define STK_RX_FAULT             5
`define STK_POLARITY             6
`define STK_BOGUS_CARRIER        7
`define STK_PAGE_RECEIVED        8
`define STK_IRQ_PENDING          9
`define STK_REMOTE_FAULT         10
`define STK_COUNT                11

`endif

/* design/phy_status_latch_registers.sv */
/*
  Link-drop cause and PHY condition status registers, read-only.
  Assumes the management frame decoder issues one-cycle read strobes with a
  5-bit address on ref_clk, and that detector inputs are on ref_clk already.
*/
`timescale 1ns/1ps
`default_nettype none
`include "phy_status_defs.svh"
// How it works
// RQ1 - each drop-cause bit latches high when its enabled mechanism drops link
// RQ2 - drop cause codes: energy 1, SNR 2, MLT3 4, rx errors 8, descrambler 0x10
// RQ3 - crossover bit reads 0 for straight pairs, 1 for swapped pairs
// RQ4 - rx fault latch sets on receive error, cleared by reading rx fault count
// RQ5 - polarity bit latches inverted polarity, cleared only by ten-meg status read or reset
// RQ6 - bogus carrier latch sets on event, cleared by reading bogus carrier count
// RQ7 - signal-detect bit shows the 100 Mb signal-detect level directly
// RQ8 - lock bit shows the 100 Mb descrambler lock level
// RQ9 - page-received bit set by new page, cleared by expansion register read
// RQ10 - interrupt-pending bit set while interrupt pends, cleared by irq source read
// RQ11 - remote fault set by partner fault, cleared by basic status read or reset
// RQ12 - jabber bit mirrors basic status jabber, unaffected by reading this register
// RQ13 - negotiation status reads 0 before auto-negotiation completes
// RQ14 - negotiation status reads 1 once auto-negotiation completes
// RQ15 - bit 3 reads 1 while MAC-side loopback is on
// RQ16 - bit 2 is full duplex; bit 1 is 1 at 10 Mb, 0 at 100 Mb
// RQ17 - bit 0 mirrors link status, unaffected by reading this register
// RQ18 - reserved bits read zero; writes never alter either register
module phy_status_latch_registers
  import phy_status_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       rdEn,
  input  wire mgmt_addr_t rdAddr,
  output logic            rdValid,
  output reg_word_t       rdData,
  input  wire logic [4:0] dropCauseEvt,
  input  wire logic       crossoverSwapped,
  input  wire logic       rxFaultEvt,
  input  wire logic       polarityInvertedEvt,
  input  wire logic       bogusCarrierEvt,
  input  wire logic       signalDetect,
  input  wire logic       descramblerLock,
  input  wire logic       pageReceivedEvt,
  input  wire logic       irqRaisedEvt,
  input  wire logic       remoteFaultEvt,
  input  wire logic       jabberDetect,
  input  wire logic       autonegDone,
  input  wire logic       macLoopback,
  input  wire logic       fullDuplex,
  input  wire logic       speed10,
  input  wire logic       linkUp
);
  sticky_bank_if #(.WIDTH(`STK_COUNT)) stk ();

  sticky_bit_bank #(.WIDTH(`STK_COUNT)) u_bank (
    .ref_clk (ref_clk),
    .rst     (rst),
    .bus     (stk.bank)
  );

  logic rdDrop;
  logic rdCond;
  assign rdDrop = rdEn && (rdAddr == `OFS_LINK_DROP_CAUSE);
  assign rdCond = rdEn && (rdAddr == `OFS_PHY_CONDITION);

  // set and clear sources for the sticky bank
  always_comb begin
    stk.setBits = '0;
    stk.clrBits = '0;
    stk.setBits[4:0] = dropCauseEvt;                                    // see RQ1
    stk.clrBits[4:0] = {5{rdDrop}};
    stk.setBits[`STK_RX_FAULT] = rxFaultEvt;                            // see RQ4
    stk.clrBits[`STK_RX_FAULT] = rdEn && (rdAddr == `OFS_RX_FAULT_COUNT);
    stk.setBits[`STK_POLARITY] = polarityInvertedEvt;                   // see RQ5
    stk.clrBits[`STK_POLARITY] = rdEn && (rdAddr == `OFS_TEN_MEG_STATUS_CTRL);
    stk.setBits[`STK_BOGUS_CARRIER] = bogusCarrierEvt;                  // see RQ6
    stk.clrBits[`STK_BOGUS_CARRIER] = rdEn && (rdAddr == `OFS_BOGUS_CARRIER_COUNT);
    stk.setBits[`STK_PAGE_RECEIVED] = pageReceivedEvt;                  // see RQ9
    stk.clrBits[`STK_PAGE_RECEIVED] = rdEn && (rdAddr == `OFS_NEGOTIATION_EXP);
    stk.setBits[`STK_IRQ_PENDING] = irqRaisedEvt;                       // see RQ10
    stk.clrBits[`STK_IRQ_PENDING] = rdEn && (rdAddr == `OFS_IRQ_SOURCE_STATUS);
    stk.setBits[`STK_REMOTE_FAULT] = remoteFaultEvt;                    // see RQ11
    stk.clrBits[`STK_REMOTE_FAULT] = rdEn && (rdAddr == `OFS_BASIC_LINK_STATUS);
  end

  sticky_vec_t held;
  assign held = stk.heldBits;

  // assembled register images; unlisted bits stay zero
  reg_word_t dropWord;
  reg_word_t condWord;
  always_comb begin
    dropWord = `RST_LINK_DROP_CAUSE;                                    // see RQ18
    dropWord[`DROP_FIELD_MSB:`DROP_FIELD_LSB] = held[4:0];              // see RQ2
    condWord = `RST_PHY_CONDITION;                                      // see RQ18
    condWord[`PCS_CROSSOVER]     = crossoverSwapped;                    // see RQ3
    condWord[`PCS_RX_FAULT]      = held[`STK_RX_FAULT];                 // see RQ4
    condWord[`PCS_POLARITY]      = held[`STK_POLARITY];                 // see RQ5
    condWord[`PCS_BOGUS_CARRIER] = held[`STK_BOGUS_CARRIER];            // see RQ6
    condWord[`PCS_SIGNAL_DETECT] = signalDetect;                        // see RQ7
    condWord[`PCS_DESCR_LOCK]    = descramblerLock;                     // see RQ8
    condWord[`PCS_PAGE_RECEIVED] = held[`STK_PAGE_RECEIVED];            // see RQ9
    condWord[`PCS_IRQ_PENDING]   = held[`STK_IRQ_PENDING];              // see RQ10
    condWord[`PCS_REMOTE_FAULT]  = held[`STK_REMOTE_FAULT];             // see RQ11
    condWord[`PCS_JABBER]        = jabberDetect;                        // see RQ12
    condWord[`PCS_AUTONEG_DONE]  = autonegDone;                         // see RQ13 RQ14
    condWord[`PCS_LOOPBACK]      = macLoopback;                         // see RQ15
    condWord[`PCS_FULL_DUPLEX]   = fullDuplex;                          // see RQ16
    condWord[`PCS_SPEED_10]      = speed10;                             // see RQ16
    condWord[`PCS_LINK_UP]       = linkUp;                              // see RQ17
  end

  // read answer: one cycle after the strobe, image taken before the clear
  logic      rdValid_reg;
  logic      rdValid_next;
  reg_word_t rdData_reg;
  reg_word_t rdData_next;

  always_comb begin
    rdValid_next = rdEn;
    rdData_next  = rdData_reg;
    if (rdDrop) begin
      rdData_next = dropWord;
    end else if (rdCond) begin
      rdData_next = condWord;
    end else if (rdEn) begin
      // other offsets belong to other banks; answer zero here
      rdData_next = '0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdValid_reg <= 1'b0;
      rdData_reg  <= '0;
    end else begin
      rdValid_reg <= rdValid_next;
      rdData_reg  <= rdData_next;
    end
  end

  assign rdValid = rdValid_reg;
  assign rdData  = rdData_reg;

  sequence condRead;
    rdEn && (rdAddr == `OFS_PHY_CONDITION);
  endsequence

  sequence dropRead;
    rdEn && (rdAddr == `OFS_LINK_DROP_CAUSE);
  endsequence

  chk_drop_latch: assert property ( // see RQ1
    @(posedge ref_clk) disable iff (rst)
    dropCauseEvt[0] ##1 (!rdDrop)[*2] |-> held[0])
    else $error("drop cause bit failed to latch");

  chk_drop_field: assert property ( // see RQ2
    @(posedge ref_clk) disable iff (rst)
    dropRead |=> rdValid && rdData[8:4] == $past(held[4:0]) && rdData[3:0] == 4'h0)
    else $error("drop cause field wrong on read");

  chk_crossover_bit: assert property ( // see RQ3
    @(posedge ref_clk) disable iff (rst)
    condRead |=> rdData[14] == $past(crossoverSwapped))
    else $error("crossover bit does not follow pair state");

  chk_rxfault_clear: assert property ( // see RQ4
    @(posedge ref_clk) disable iff (rst)
    rdEn && rdAddr == `OFS_RX_FAULT_COUNT && !rxFaultEvt |=> !held[`STK_RX_FAULT])
    else $error("rx fault latch not cleared by count read");

  chk_polarity_keep: assert property ( // see RQ5
    @(posedge ref_clk) disable iff (rst)
    held[`STK_POLARITY] && !(rdEn && rdAddr == `OFS_TEN_MEG_STATUS_CTRL)
      |=> held[`STK_POLARITY])
    else $error("polarity bit lost without its clearing read");

  chk_carrier_setwin: assert property ( // see RQ6
    @(posedge ref_clk) disable iff (rst)
    bogusCarrierEvt ##1 condRead |=> rdData[11])
    else $error("bogus carrier event not reported");

  chk_live_levels: assert property ( // see RQ7 RQ8
    @(posedge ref_clk) disable iff (rst)
    condRead |=> rdData[10:9] == $past({signalDetect, descramblerLock}))
    else $error("signal detect or lock bit wrong");

  chk_reserved_zero: assert property ( // see RQ18
    @(posedge ref_clk) disable iff (rst)
    condRead ##1 rdValid |-> !rdData[15])
    else $error("reserved bit reads nonzero");

  chk_link_mirror: assert property ( // see RQ17
    @(posedge ref_clk) disable iff (rst)
    condRead ##1 condRead |=> rdData[0] == $past(linkUp))
    else $error("link bit not mirrored on repeated reads");

  // an event on the edge of its own clearing read must still be held
  chk_event_latch: assert property ( // see RQ1 RQ4 RQ6 RQ9 RQ10 RQ11
    @(posedge ref_clk) disable iff (rst)
    (|stk.setBits) |=> (held & $past(stk.setBits)) == $past(stk.setBits))
    else $error("event lost against its clearing read");

  chk_drop_clear: assert property ( // see RQ1
    @(posedge ref_clk) disable iff (rst)
    rdDrop && dropCauseEvt == 5'h00 |=> held[4:0] == 5'h00)
    else $error("drop causes not cleared by their own read");

  chk_drop_reserved: assert property ( // see RQ18
    @(posedge ref_clk) disable iff (rst)
    dropRead |=> rdData[15:9] == 7'h00)
    else $error("reserved drop register bits read nonzero");

  chk_page_clear: assert property ( // see RQ9
    @(posedge ref_clk) disable iff (rst)
    rdEn && rdAddr == `OFS_NEGOTIATION_EXP && !pageReceivedEvt
      |=> !held[`STK_PAGE_RECEIVED])
    else $error("page received bit not cleared by expansion read");

  chk_irq_clear: assert property ( // see RQ10
    @(posedge ref_clk) disable iff (rst)
    rdEn && rdAddr == `OFS_IRQ_SOURCE_STATUS && !irqRaisedEvt
      |=> !held[`STK_IRQ_PENDING])
    else $error("interrupt pending bit not cleared by source read");

  chk_remote_clear: assert property ( // see RQ11
    @(posedge ref_clk) disable iff (rst)
    rdEn && rdAddr == `OFS_BASIC_LINK_STATUS && !remoteFaultEvt
      |=> !held[`STK_REMOTE_FAULT])
    else $error("remote fault bit not cleared by basic status read");

  chk_sticky_image: assert property ( // see RQ4 RQ5 RQ6 RQ9 RQ10 RQ11
    @(posedge ref_clk) disable iff (rst)
    condRead |=> {rdData[13:11], rdData[8:6]} == $past({held[`STK_RX_FAULT],
      held[`STK_POLARITY], held[`STK_BOGUS_CARRIER], held[`STK_PAGE_RECEIVED],
      held[`STK_IRQ_PENDING], held[`STK_REMOTE_FAULT]}))
    else $error("latched condition bits wrong on read");

  chk_mirror_levels: assert property ( // see RQ12 RQ13 RQ14 RQ15 RQ16 RQ17
    @(posedge ref_clk) disable iff (rst)
    condRead |=> rdData[5:0] ==
      $past({jabberDetect, autonegDone, macLoopback, fullDuplex, speed10, linkUp}))
    else $error("mirrored status levels wrong on read");

endmodule
`default_nettype wire

/* design/phy_status_pkg.sv */
/*
  Types shared by the status latch registers, the host model and the bench.
  Assumes the constants header for widths of the sticky bank.
*/
`include "phy_status_defs.svh"
package phy_status_pkg;
  typedef logic [15:0]             reg_word_t;
  typedef logic [4:0]              mgmt_addr_t;
  typedef logic [`STK_COUNT-1:0]   sticky_vec_t;
endpackage

/* design/sticky_bank_if.sv */
/*
  Carrier between the status registers and the sticky bit bank.
  Assumes a single clock domain; all signals are same-cycle levels.
*/
`timescale 1ns/1ps
`default_nettype none
interface sticky_bank_if #(parameter int WIDTH = 11);
  logic [WIDTH-1:0] setBits;
  logic [WIDTH-1:0] clrBits;
  logic [WIDTH-1:0] heldBits;
  modport bank (input setBits, input clrBits, output heldBits);
  modport user (output setBits, output clrBits, input heldBits);
endinterface
`default_nettype wire

/* design/sticky_bit_bank.sv */
/*
  Bank of sticky status bits: each sets on its event, clears on its clear.
  Assumes set and clear come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sticky_bit_bank #(
  parameter int WIDTH = 11
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  sticky_bank_if.bank     bus
);
  if (WIDTH < 1) begin : g_bad_width
    $error("sticky_bit_bank needs at least one bit");
  end

  logic [WIDTH-1:0] held_reg;
  logic [WIDTH-1:0] held_next;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // set beats clear so an event landing on the clearing read survives
      always_comb begin
        held_next[i] = bus.setBits[i] | (held_reg[i] & ~bus.clrBits[i]);
      end
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          held_reg[i] <= 1'b0;
        end else begin
          held_reg[i] <= held_next[i];
        end
      end
    end
  endgenerate

  assign bus.heldBits = held_reg;
endmodule
`default_nettype wire

/* dv/mgmt_host_model.sv */
/*
  Management host model: issues one-cycle read strobes and collects answers.
  Assumes the design answers with rdValid on the taking edge; the answer is sampled at the next falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module mgmt_host_model
  import phy_status_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire logic      rdValid,
  input  wire reg_word_t rdData,
  output logic           rdEn,
  output mgmt_addr_t     rdAddr
);
  initial begin
    rdEn = 1'b0;
    rdAddr = 5'h1f;
  end

  task automatic rd(input mgmt_addr_t a, output reg_word_t d);
    @(posedge ref_clk);
    rdEn <= 1'b1;
    rdAddr <= a;
    @(posedge ref_clk);
    rdEn <= 1'b0;
    // address is no longer qualified: show its inverse, not a stale copy
    rdAddr <= ~a;
    @(negedge ref_clk);
    d = (rdValid === 1'b1) ? rdData : 16'hxxxx;
  endtask

  // two strobes on consecutive edges; each answer taken while it stands
  task automatic rd2(input mgmt_addr_t a, input mgmt_addr_t b,
                     output reg_word_t d1, output reg_word_t d2);
    @(posedge ref_clk);
    rdEn <= 1'b1;
    rdAddr <= a;
    @(posedge ref_clk);
    rdAddr <= b;
    @(negedge ref_clk);
    d1 = (rdValid === 1'b1) ? rdData : 16'hxxxx;
    @(posedge ref_clk);
    rdEn <= 1'b0;
    rdAddr <= ~b;
    @(negedge ref_clk);
    d2 = (rdValid === 1'b1) ? rdData : 16'hxxxx;
  endtask
endmodule
`default_nettype wire

/* dv/test_phy_status_latch_registers.sv */
/*
  Self-checking bench for the status latch registers: reads through the host
  model, drives detector events and live levels. Assumes one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "phy_status_defs.svh"
module test_phy_status_latch_registers;
  import phy_status_pkg::*;
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic       rdEn;
  mgmt_addr_t rdAddr;
  logic       rdValid;
  reg_word_t  rdData;
  logic [4:0] drop = 5'h00;
  logic [5:0] ev = 6'h00;
  logic [8:0] lvl = 9'h000;
  int         nFail = 0;
  int         testsRun = 0;
  int         cycles = 0;
  localparam int evBit[6] = '{13, 12, 11, 8, 7, 6};
  localparam logic [4:0] evClr[6] = '{5'h15, 5'h1a, 5'h14, 5'h06, 5'h12, 5'h01};
  localparam int lvBit[9] = '{14, 10, 9, 5, 4, 3, 2, 1, 0};

  always #4 ref_clk = ~ref_clk;

  mgmt_host_model i_host (.ref_clk(ref_clk), .rdValid(rdValid), .rdData(rdData),
    .rdEn(rdEn), .rdAddr(rdAddr));

  phy_status_latch_registers i_dut (.ref_clk(ref_clk), .rst(rst), .rdEn(rdEn),
    .rdAddr(rdAddr), .rdValid(rdValid), .rdData(rdData), .dropCauseEvt(drop),
    .crossoverSwapped(lvl[0]), .rxFaultEvt(ev[0]), .polarityInvertedEvt(ev[1]),
    .bogusCarrierEvt(ev[2]), .signalDetect(lvl[1]), .descramblerLock(lvl[2]),
    .pageReceivedEvt(ev[3]), .irqRaisedEvt(ev[4]), .remoteFaultEvt(ev[5]),
    .jabberDetect(lvl[3]), .autonegDone(lvl[4]), .macLoopback(lvl[5]),
    .fullDuplex(lvl[6]), .speed10(lvl[7]), .linkUp(lvl[8]));

  task automatic testDone();
    $display("compares %0d mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input mgmt_addr_t a, input reg_word_t d, input reg_word_t exp);
    testsRun++;
    if (d !== exp) begin
      nFail++;
      $display("BAD t=%0t addr %h got %h want %h", $time, a, d, exp);
    end
  endtask

  task automatic rdc(input mgmt_addr_t a, input reg_word_t exp);
    reg_word_t d;
    i_host.rd(a, d);
    chk(a, d, exp);
  endtask

  // back-to-back pair: the second strobe follows the first with no gap
  task automatic rdc2(input mgmt_addr_t a, input mgmt_addr_t b, input reg_word_t expA,
                      input reg_word_t expB);
    reg_word_t dA;
    reg_word_t dB;
    i_host.rd2(a, b, dA, dB);
    chk(a, dA, expA);
    chk(b, dB, expB);
  endtask

  // ceiling well above the fewer than two hundred cycles the tests need
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      nFail++;
      testDone();
    end
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rdc(`OFS_PHY_CONDITION, 16'h0000);
    rdc(`OFS_LINK_DROP_CAUSE, 16'h0000);
    rdc(5'h03, 16'h0000);
    $display("test reset ok");
    for (int i = 0; i < 5; i++) begin
      @(posedge ref_clk);
      drop <= 5'h01 << i;
      @(posedge ref_clk);
      drop <= 5'h00;
      rdc(`OFS_LINK_DROP_CAUSE, 16'h0001 << (i + 4));
      rdc(`OFS_LINK_DROP_CAUSE, 16'h0000);
    end
    $display("test drop causes ok");
    for (int i = 0; i < 9; i++) begin
      @(posedge ref_clk);
      lvl <= 9'h001 << i;
      rdc(`OFS_PHY_CONDITION, 16'h0001 << lvBit[i]);
    end
    @(posedge ref_clk);
    lvl <= 9'h1ff;
    rdc(`OFS_PHY_CONDITION, 16'h463f);
    rdc2(`OFS_PHY_CONDITION, `OFS_PHY_CONDITION, 16'h463f, 16'h463f);
    @(posedge ref_clk);
    lvl <= 9'h000;
    $display("test live levels ok");
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk);
      ev <= 6'h01 << i;
      // event sampled one edge ahead of the read strobe
      fork
        rdc(`OFS_PHY_CONDITION, 16'h0001 << evBit[i]);
        begin
          @(posedge ref_clk);
          ev <= 6'h00;
        end
      join
      // reading this register itself must leave the latch standing
      rdc(`OFS_PHY_CONDITION, 16'h0001 << evBit[i]);
      // a fresh event on the clearing read's edge must survive it
      fork
        rdc(evClr[i], 16'h0000);
        begin
          @(posedge ref_clk);
          ev <= 6'h01 << i;
          @(posedge ref_clk);
          ev <= 6'h00;
        end
      join
      rdc(`OFS_PHY_CONDITION, 16'h0001 << evBit[i]);
      rdc2(evClr[i], `OFS_PHY_CONDITION, 16'h0000, 16'h0000);
    end
    $display("test sticky latches ok");
    @(posedge ref_clk);
    ev <= 6'h3f;
    drop <= 5'h1f;
    @(posedge ref_clk);
    ev <= 6'h00;
    drop <= 5'h00;
    rdc(`OFS_PHY_CONDITION, 16'h39c0);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rdc(`OFS_PHY_CONDITION, 16'h0000);
    rdc(`OFS_LINK_DROP_CAUSE, 16'h0000);
    $display("test mid-run reset ok");
    testDone();
  end
endmodule
`default_nettype wire
